// ### ccgc_consts.vh
`ifndef CCGC_CONSTS_VH
`define CCGC_CONSTS_VH

// ----------------------------------------------------------------------------
// Configuration space locations
// ----------------------------------------------------------------------------
`define CCGC_SYSCTL_ADDR      8'h80
`define CCGC_GENCTL_BYTE_ADDR 8'h86
`define CCGC_GENCTL_DW_ADDR   8'h84
`define CCGC_ADDR_W           8

// ----------------------------------------------------------------------------
// System control register, low byte
// ----------------------------------------------------------------------------
`define CCGC_SYS_ID_LOCK_BIT  5
`define CCGC_SYS_CPAR_BIT     4
`define CCGC_SYS_RSVD3_BIT    3
`define CCGC_SYS_KEEP_BIT     1
`define CCGC_SYS_PINSEL_BIT   0
`define CCGC_SYS_ID_LOCK_RST  1'b1
`define CCGC_SYS_CPAR_RST     1'b0
`define CCGC_SYS_RSVD3_RST    1'b0
`define CCGC_SYS_KEEP_RST     1'b0
`define CCGC_SYS_PINSEL_RST   1'b0

// ----------------------------------------------------------------------------
// General control register, 16 bits in dword lanes 3:2
// ----------------------------------------------------------------------------
`define CCGC_GEN_PSW_BIT      10
`define CCGC_GEN_SKTB_BIT     4
`define CCGC_GEN_FWDIS_BIT    3
`define CCGC_GEN_ARB_LSB      0
`define CCGC_GEN_LANE_LSB     16
`define CCGC_GEN_PSW_RST      1'b0
`define CCGC_GEN_SKTB_RST     1'b0
`define CCGC_GEN_FWDIS_RST    1'b0
`define CCGC_GEN_ARB_RST      2'h0

// ----------------------------------------------------------------------------
// Top-level arbitration modes
// ----------------------------------------------------------------------------
`define CCGC_ARB_FW_FIRST     2'h0
`define CCGC_ARB_CARD_FIRST   2'h1
`define CCGC_ARB_FAIR_A       2'h2
`define CCGC_ARB_FAIR_B       2'h3

`endif

// ### ccgc_arbiter.v
`timescale 1ns/1ps
`default_nettype none
`include "ccgc_consts.vh"

module ccgc_arbiter (
  // Clock and reset
  input  wire       clock_i,
  input  wire       rstn_i,
  // Arbitration mode
  input  wire [1:0] mode_i,
  // Requests
  input  wire       fw_req_i,
  input  wire       card_req_i,
  // Grants
  output reg        fw_gnt_o,
  output reg        card_gnt_o
);

  reg fw_gnt_nxt;
  reg card_gnt_nxt;
  reg last_fw_r;

  // --------------------------------------------------------------------------
  // Grant selection
  // --------------------------------------------------------------------------
  always @* begin
    fw_gnt_nxt   = 1'b0;
    card_gnt_nxt = 1'b0;
    if (fw_req_i && card_req_i) begin
      case (mode_i)
        `CCGC_ARB_FW_FIRST: begin
          fw_gnt_nxt = 1'b1;
        end
        `CCGC_ARB_CARD_FIRST: begin
          card_gnt_nxt = 1'b1;
        end
        default: begin
          fw_gnt_nxt   = ~last_fw_r;
          card_gnt_nxt = last_fw_r;
        end
      endcase
    end else begin
      fw_gnt_nxt   = fw_req_i;
      card_gnt_nxt = card_req_i;
    end
  end

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      fw_gnt_o   <= 1'b0;
      card_gnt_o <= 1'b0;
      last_fw_r  <= 1'b0;
    end else begin
      fw_gnt_o   <= fw_gnt_nxt;
      card_gnt_o <= card_gnt_nxt;
      if (fw_gnt_nxt) begin
        last_fw_r <= 1'b1;
      end else if (card_gnt_nxt) begin
        last_fw_r <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### ccgc_global_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "ccgc_consts.vh"

// Contract
// - While id_write_lock is 1 (its reset value) the identification registers are read-only.
// - Card data parity errors reach SERR only while card_parity_report_enable is 1.
// - System control bit 2 and general control bits 15-11, 9-5 and 2 read as zero.
// - While clock_keep_alive is 1 the clock-run line is held so neither clock may stop.
// - Clock_keep_alive is one setting shared by every function.
// - With shared_pin_select at 1 the wake event drives the shared pin.
// - With shared_pin_select at 0 and ring_indicate_enable at 1 the ring output drives it.
// - With both bits at 0 the shared pin is released to high impedance.
// - Power_switch_type_select picks the 1.8-V switch at 0 and the 12-V switch at 1.
// - Second_socket_disable turns off the second socket function.
// - Firewire_function_disable makes that function inaccessible and inert.
// - Top_arbitration_select 00 favours firewire, 01 favours card, 10 and 11 are fair.
// - Global-reset-only bits return to their reset values on global_reset_n alone and survive the bus reset.
module ccgc_global_ctrl (
  // Clock and resets
  input  wire        clock_i,
  input  wire        rstn_i,
  input  wire        global_reset_n_i,
  // Configuration space access
  input  wire        cfg_wr_i,
  input  wire        cfg_rd_i,
  input  wire [7:0]  cfg_addr_i,
  input  wire [3:0]  cfg_byte_en_i,
  input  wire [31:0] cfg_wdata_i,
  output reg  [31:0] cfg_rdata_o,
  output reg         cfg_rd_valid_o,
  // Identification registers
  output reg         id_write_enable_o,
  // Parity reporting
  input  wire        card_parity_error_i,
  output reg         serr_card_parity_o,
  // Clock run
  input  wire        clkrun_n_i,
  output reg         clkrun_n_o,
  output reg         clkrun_n_oe_o,
  output reg         card_bus_clock_stop_allow_o,
  // Shared wake and ring-indicate pin
  input  wire        pme_event_i,
  input  wire        ring_indicate_output_i,
  input  wire        ring_indicate_enable_i,
  output reg         wake_ring_shared_pin_o,
  output reg         wake_ring_shared_pin_oe_o,
  // Function control
  output reg         power_switch_type_select_o,
  output reg         second_socket_disable_o,
  output reg         firewire_function_disable_o,
  // Top-level arbitration
  input  wire        fw_req_i,
  input  wire        card_req_i,
  output wire        fw_gnt_o,
  output wire        card_gnt_o
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg        id_write_lock_r;
  reg        card_parity_report_enable_r;
  reg        sys_rsvd3_r;
  reg        clock_keep_alive_r;
  reg        shared_pin_select_r;
  reg        power_switch_type_select_r;
  reg        second_socket_disable_r;
  reg        firewire_function_disable_r;
  reg  [1:0] top_arbitration_select_r;

  reg [31:0] cfg_rdata_nxt;
  reg        pin_oe_nxt;
  reg        pin_val_nxt;

  wire       sys_hit;
  wire       gen_hit;
  wire       sys_wr;
  wire       gen_lo_wr;
  wire       gen_hi_wr;
  wire [7:0] sys_byte;
  wire [15:0] gen_word;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function match_dword;
    input [7:0] addr;
    input [7:0] base;
    begin
      match_dword = (addr[7:2] == base[7:2]);
    end
  endfunction

  assign sys_hit   = match_dword(cfg_addr_i, `CCGC_SYSCTL_ADDR);
  assign gen_hit   = match_dword(cfg_addr_i, `CCGC_GENCTL_DW_ADDR);

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  // Any byte address inside a dword hits that register; the byte enables
  // alone choose which lanes are written.
  assign sys_wr    = cfg_wr_i && sys_hit && cfg_byte_en_i[0];
  assign gen_lo_wr = cfg_wr_i && gen_hit && cfg_byte_en_i[2];
  assign gen_hi_wr = cfg_wr_i && gen_hit && cfg_byte_en_i[3];

  // --------------------------------------------------------------------------
  // Global-reset-only system control bits
  // --------------------------------------------------------------------------
  // These bits ignore the bus reset so that a host bus reset does not lose
  // the board setup that firmware placed there before the operating system.
  always @(posedge clock_i) begin
    if (!global_reset_n_i) begin
      id_write_lock_r             <= `CCGC_SYS_ID_LOCK_RST;
      card_parity_report_enable_r <= `CCGC_SYS_CPAR_RST;
      sys_rsvd3_r                 <= `CCGC_SYS_RSVD3_RST;
      clock_keep_alive_r          <= `CCGC_SYS_KEEP_RST;
      shared_pin_select_r         <= `CCGC_SYS_PINSEL_RST;
    end else if (sys_wr) begin
      id_write_lock_r             <= cfg_wdata_i[`CCGC_SYS_ID_LOCK_BIT];
      card_parity_report_enable_r <= cfg_wdata_i[`CCGC_SYS_CPAR_BIT];
      sys_rsvd3_r                 <= cfg_wdata_i[`CCGC_SYS_RSVD3_BIT];
      clock_keep_alive_r          <= cfg_wdata_i[`CCGC_SYS_KEEP_BIT];
      shared_pin_select_r         <= cfg_wdata_i[`CCGC_SYS_PINSEL_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Global-reset-only general control bits
  // --------------------------------------------------------------------------
  // Each byte lane is written on its own so that a byte access to one half of
  // the register leaves the other half untouched.
  always @(posedge clock_i) begin
    if (!global_reset_n_i) begin
      power_switch_type_select_r  <= `CCGC_GEN_PSW_RST;
      firewire_function_disable_r <= `CCGC_GEN_FWDIS_RST;
      top_arbitration_select_r    <= `CCGC_GEN_ARB_RST;
    end else begin
      if (gen_lo_wr) begin
        firewire_function_disable_r <=
          cfg_wdata_i[`CCGC_GEN_LANE_LSB + `CCGC_GEN_FWDIS_BIT];
        top_arbitration_select_r    <=
          cfg_wdata_i[`CCGC_GEN_LANE_LSB + `CCGC_GEN_ARB_LSB +: 2];
      end
      if (gen_hi_wr) begin
        power_switch_type_select_r  <=
          cfg_wdata_i[`CCGC_GEN_LANE_LSB + `CCGC_GEN_PSW_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bus-reset bits
  // --------------------------------------------------------------------------
  // Socket B disable is an ordinary bit: the bus reset clears it as well as
  // the global reset, unlike its neighbours in the same register.
  always @(posedge clock_i) begin
    if (!rstn_i || !global_reset_n_i) begin
      second_socket_disable_r <= `CCGC_GEN_SKTB_RST;
    end else if (gen_lo_wr) begin
      second_socket_disable_r <=
        cfg_wdata_i[`CCGC_GEN_LANE_LSB + `CCGC_GEN_SKTB_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------------
  assign sys_byte = {2'h0,
                     id_write_lock_r,
                     card_parity_report_enable_r,
                     sys_rsvd3_r,
                     1'b0,
                     clock_keep_alive_r,
                     shared_pin_select_r};

  assign gen_word = {5'h00,
                     power_switch_type_select_r,
                     5'h00,
                     second_socket_disable_r,
                     firewire_function_disable_r,
                     1'b0,
                     top_arbitration_select_r};

  always @* begin
    cfg_rdata_nxt = 32'h0000_0000;
    if (sys_hit) begin
      cfg_rdata_nxt = {24'h00_0000, sys_byte};
    end else if (gen_hit) begin
      cfg_rdata_nxt = {gen_word, 16'h0000};
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // Only a read loads the data register, so the answer stays readable until
  // the next read even while writes go on.
  always @(posedge clock_i) begin
    if (!rstn_i || !global_reset_n_i) begin
      cfg_rdata_o    <= 32'h0000_0000;
      cfg_rd_valid_o <= 1'b0;
    end else begin
      cfg_rd_valid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= cfg_rdata_nxt;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Shared pin routing
  // --------------------------------------------------------------------------
  // The select bit wins over ring enable so that a wake event is never hidden
  // behind a ring indicate setup.
  always @* begin
    pin_oe_nxt  = 1'b0;
    pin_val_nxt = 1'b0;
    if (shared_pin_select_r) begin
      pin_oe_nxt  = 1'b1;
      pin_val_nxt = pme_event_i;
    end else if (ring_indicate_enable_i) begin
      pin_oe_nxt  = 1'b1;
      pin_val_nxt = ring_indicate_output_i;
    end
  end

  always @(posedge clock_i) begin
    if (!rstn_i || !global_reset_n_i) begin
      wake_ring_shared_pin_o    <= 1'b0;
      wake_ring_shared_pin_oe_o <= 1'b0;
    end else begin
      wake_ring_shared_pin_o    <= pin_val_nxt;
      wake_ring_shared_pin_oe_o <= pin_oe_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Identification and parity outputs
  // --------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rstn_i || !global_reset_n_i) begin
      id_write_enable_o  <= 1'b0;
      serr_card_parity_o <= 1'b0;
    end else begin
      id_write_enable_o  <= ~id_write_lock_r;
      serr_card_parity_o <= card_parity_error_i &
                            card_parity_report_enable_r;
    end
  end

  // --------------------------------------------------------------------------
  // Clock-run outputs
  // --------------------------------------------------------------------------
  // The clock-run line is low active and open drain; while keep-alive is set
  // the block pulls it low whenever the host releases it to ask for a stop.
  always @(posedge clock_i) begin
    if (!rstn_i || !global_reset_n_i) begin
      clkrun_n_o                  <= 1'b0;
      clkrun_n_oe_o               <= 1'b0;
      card_bus_clock_stop_allow_o <= 1'b1;
    end else begin
      clkrun_n_o                  <= 1'b0;
      clkrun_n_oe_o               <= clock_keep_alive_r & clkrun_n_i;
      card_bus_clock_stop_allow_o <= ~clock_keep_alive_r;
    end
  end

  // --------------------------------------------------------------------------
  // Function control outputs
  // --------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rstn_i || !global_reset_n_i) begin
      power_switch_type_select_o  <= 1'b0;
      second_socket_disable_o     <= 1'b0;
      firewire_function_disable_o <= 1'b0;
    end else begin
      power_switch_type_select_o  <= power_switch_type_select_r;
      second_socket_disable_o     <= second_socket_disable_r;
      firewire_function_disable_o <= firewire_function_disable_r;
    end
  end

  // --------------------------------------------------------------------------
  // Top-level arbitration
  // --------------------------------------------------------------------------
  // A disabled firewire function cannot win the bus. The grant history restarts on
  // either reset, so fair mode opens with the firewire side unless firewire took the last grant since then.
  ccgc_arbiter u_arb (
    .clock_i    (clock_i),
    .rstn_i     (rstn_i & global_reset_n_i),
    .mode_i     (top_arbitration_select_r),
    .fw_req_i   (fw_req_i & ~firewire_function_disable_r),
    .card_req_i (card_req_i),
    .fw_gnt_o   (fw_gnt_o),
    .card_gnt_o (card_gnt_o)
  );

endmodule
`default_nettype wire

// ### ccgc_global_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccgc_consts.vh"
module ccgc_global_ctrl_props (
  // Clock and resets
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        global_reset_n_i,
  // Configuration access
  input wire logic        cfg_wr_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [3:0]  cfg_byte_en_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rd_valid_o,
  // Controlled outputs and their causes
  input wire logic        id_write_enable_o,
  input wire logic        card_parity_error_i,
  input wire logic        serr_card_parity_o,
  input wire logic        clkrun_n_i,
  input wire logic        clkrun_n_oe_o,
  input wire logic        card_bus_clock_stop_allow_o,
  input wire logic        ring_indicate_enable_i,
  input wire logic        wake_ring_shared_pin_oe_o,
  input wire logic        power_switch_type_select_o,
  input wire logic        second_socket_disable_o,
  input wire logic        firewire_function_disable_o,
  input wire logic        fw_req_i,
  input wire logic        card_req_i,
  input wire logic        fw_gnt_o,
  input wire logic        card_gnt_o
);
  // ---------------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------------
  // Masks the first edge after any reset, where pin outputs still hold reset values.
  logic up_r;
  always @(posedge clock_i) begin
    if (!rstn_i || !global_reset_n_i) up_r <= 1'h0;
    else up_r <= 1'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i || !global_reset_n_i);
  sequence s_sys_wr;
    cfg_wr_i && {cfg_addr_i[7:2], 2'h0} == `CCGC_SYSCTL_ADDR && cfg_byte_en_i[0];
  endsequence
  sequence s_gen_wr;
    cfg_wr_i && {cfg_addr_i[7:2], 2'h0} == `CCGC_GENCTL_DW_ADDR && cfg_byte_en_i[3:2] == 2'h3;
  endsequence
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  a_id_lock_copy: assert property (s_sys_wr |-> ##2
    id_write_enable_o == !$past(cfg_wdata_i[5], 2))
    else $error("id write enable does not follow the lock bit");
  a_keep_alive_copy: assert property (s_sys_wr |-> ##2
    card_bus_clock_stop_allow_o == !$past(cfg_wdata_i[1], 2))
    else $error("clock stop permission does not follow keep alive");
  a_func_ctrl_copy: assert property (s_gen_wr |-> ##2
    power_switch_type_select_o == $past(cfg_wdata_i[26], 2) &&
    second_socket_disable_o == $past(cfg_wdata_i[20], 2) &&
    firewire_function_disable_o == $past(cfg_wdata_i[19], 2))
    else $error("function controls do not follow the written bits");
  a_serr_cause: assert property (serr_card_parity_o |-> $past(card_parity_error_i))
    else $error("parity error reported without a card parity error");
  a_clkrun_hold: assert property (clkrun_n_oe_o ==
    (!card_bus_clock_stop_allow_o && $past(clkrun_n_i)))
    else $error("clock run line not held as keep alive demands");
  a_pin_release: assert property (up_r && !wake_ring_shared_pin_oe_o |->
    !$past(ring_indicate_enable_i))
    else $error("shared pin released while ring indicate was enabled");
  a_fw_gnt_gate: assert property (fw_gnt_o |->
    !firewire_function_disable_o && !card_gnt_o && $past(fw_req_i))
    else $error("firewire grant without request or while disabled");
  a_card_grant: assert property (card_req_i && !fw_req_i |=> card_gnt_o && !fw_gnt_o)
    else $error("lone card request not granted");
  a_sys_rsvd_zero: assert property (cfg_rd_i &&
    {cfg_addr_i[7:2], 2'h0} == `CCGC_SYSCTL_ADDR |=>
    cfg_rd_valid_o && cfg_rdata_o[31:6] == 26'h0 && !cfg_rdata_o[2])
    else $error("system control reserved bits not zero");
  a_gen_rsvd_zero: assert property (cfg_rd_i &&
    {cfg_addr_i[7:2], 2'h0} == `CCGC_GENCTL_DW_ADDR |=> cfg_rd_valid_o &&
    cfg_rdata_o[15:0] == 16'h0 && cfg_rdata_o[31:27] == 5'h0 &&
    cfg_rdata_o[25:21] == 5'h0 && !cfg_rdata_o[18])
    else $error("general control reserved bits not zero");
endmodule
bind ccgc_global_ctrl ccgc_global_ctrl_props i_props (
  .clock_i, .rstn_i, .global_reset_n_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_byte_en_i,
  .cfg_wdata_i, .cfg_rdata_o, .cfg_rd_valid_o, .id_write_enable_o, .card_parity_error_i,
  .serr_card_parity_o, .clkrun_n_i, .clkrun_n_oe_o, .card_bus_clock_stop_allow_o,
  .ring_indicate_enable_i, .wake_ring_shared_pin_oe_o, .power_switch_type_select_o,
  .second_socket_disable_o, .firewire_function_disable_o, .fw_req_i, .card_req_i,
  .fw_gnt_o, .card_gnt_o
);
`default_nettype wire

// ### ccgc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccgc_host_model (
  // Device side of the clock run wire
  input  wire logic dev_clkrun_n_i,
  input  wire logic dev_clkrun_n_oe_i,
  // Host request to stop the clock
  input  wire logic host_stop_i,
  // Resolved wire level
  output wire logic clkrun_line_o
);
  // The host holds the line low while the clock runs and lets the pull-up raise it
  // to ask for a stop; a device pulling low overrides the pull-up.
  assign clkrun_line_o = (dev_clkrun_n_oe_i === 1'h1) ? dev_clkrun_n_i : host_stop_i;
endmodule
`default_nettype wire

// ### ccgc_global_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccgc_consts.vh"
module ccgc_global_ctrl_bench;
  logic        clock_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic        global_reset_n_i = 1'h0;
  logic        cfg_wr_i = 1'h0;
  logic        cfg_rd_i = 1'h0;
  logic [7:0]  cfg_addr_i = 8'h00;
  logic [3:0]  cfg_byte_en_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic        card_parity_error_i = 1'h0;
  logic        pme_event_i = 1'h1;
  logic        ring_indicate_output_i = 1'h0;
  logic        ring_indicate_enable_i = 1'h0;
  logic        fw_req_i = 1'h0;
  logic        card_req_i = 1'h0;
  logic        host_stop = 1'h0;
  logic [1:0]  g0;
  logic [3:0]  arb_exp [4] = '{4'hA, 4'h5, 4'h9, 4'h9};
  int          n_mismatch = 0;
  int          n_compared = 0;
  wire         clkrun_n_i, cfg_rd_valid_o, id_write_enable_o, serr_card_parity_o;
  wire  [31:0] cfg_rdata_o;
  wire         clkrun_n_o, clkrun_n_oe_o, card_bus_clock_stop_allow_o, fw_gnt_o, card_gnt_o;
  wire         wake_ring_shared_pin_o, wake_ring_shared_pin_oe_o, power_switch_type_select_o;
  wire         second_socket_disable_o, firewire_function_disable_o;
  always #20 clock_i = ~clock_i;
  ccgc_global_ctrl i_dut (
    .clock_i, .rstn_i, .global_reset_n_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_byte_en_i,
    .cfg_wdata_i, .cfg_rdata_o, .cfg_rd_valid_o, .id_write_enable_o, .card_parity_error_i,
    .serr_card_parity_o, .clkrun_n_i, .clkrun_n_o, .clkrun_n_oe_o, .card_bus_clock_stop_allow_o,
    .pme_event_i, .ring_indicate_output_i, .ring_indicate_enable_i, .wake_ring_shared_pin_o,
    .wake_ring_shared_pin_oe_o, .power_switch_type_select_o, .second_socket_disable_o,
    .firewire_function_disable_o, .fw_req_i, .card_req_i, .fw_gnt_o, .card_gnt_o
  );
  ccgc_host_model i_host (
    .dev_clkrun_n_i(clkrun_n_o), .dev_clkrun_n_oe_i(clkrun_n_oe_o), .host_stop_i(host_stop),
    .clkrun_line_o(clkrun_n_i)
  );
  // ---------------------------------------------------------------------------
  // Access and checking tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic bus_only);
    rstn_i = 1'h0;
    global_reset_n_i = bus_only;
    repeat (6) @(negedge clock_i);
    rstn_i = 1'h1;
    global_reset_n_i = 1'h1;
    @(negedge clock_i);
  endtask
  // A write lands at the next edge; two more edges let the output copies settle.
  task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
    cfg_addr_i = addr;
    cfg_byte_en_i = be;
    cfg_wdata_i = data;
    cfg_wr_i = 1'h1;
    @(negedge clock_i);
    cfg_wr_i = 1'h0;
    repeat (2) @(negedge clock_i);
  endtask
  task automatic cfg_read(input logic [7:0] addr, input logic [31:0] exp);
    cfg_addr_i = addr;
    cfg_rd_i = 1'h1;
    @(negedge clock_i);
    cfg_rd_i = 1'h0;
    for (int i = 0; i < 4 && cfg_rd_valid_o !== 1'h1; i++) @(negedge clock_i);
    if (cfg_rd_valid_o !== 1'h1) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end else check(cfg_rdata_o, exp);
    @(negedge clock_i);
  endtask
  task automatic clkrun_walk(input logic keep);
    logic prev;
    host_stop = 1'h1;
    @(negedge clock_i);
    for (int i = 0; i < 4; i++) begin
      prev = clkrun_n_i;
      @(negedge clock_i);
      check(clkrun_n_oe_o, keep & prev);
    end
    check(card_bus_clock_stop_allow_o, !keep);
    check(clkrun_n_o, 1'h0);
    host_stop = 1'h0;
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    do_reset(1'h0);
    check(card_bus_clock_stop_allow_o, 1'h1);
    check(id_write_enable_o, 1'h0);
    cfg_read(`CCGC_SYSCTL_ADDR, 32'h0000_0020);
    cfg_read(`CCGC_GENCTL_DW_ADDR, 32'h0);
    cfg_write(`CCGC_SYSCTL_ADDR, 4'hF, 32'hFFFF_FF17);
    cfg_read(`CCGC_SYSCTL_ADDR, 32'h0000_0013);
    check(id_write_enable_o, 1'h1);
    card_parity_error_i = 1'h1;
    @(negedge clock_i);
    check(serr_card_parity_o, 1'h1);
    cfg_write(`CCGC_SYSCTL_ADDR, 4'h1, 32'h0000_0003);
    check(serr_card_parity_o, 1'h0);
    card_parity_error_i = 1'h0;
    clkrun_walk(1'h1);
    cfg_write(`CCGC_SYSCTL_ADDR, 4'h1, 32'h0000_0001);
    clkrun_walk(1'h0);
    for (int k = 0; k < 3; k++) begin
      ring_indicate_enable_i = (k == 1);
      ring_indicate_output_i = (k == 1);
      pme_event_i = (k == 0);
      cfg_write(`CCGC_SYSCTL_ADDR, 4'h1, {30'h0, 1'h0, k == 0});
      check(wake_ring_shared_pin_oe_o, k < 2);
      check(wake_ring_shared_pin_o & wake_ring_shared_pin_oe_o, k < 2);
    end
    cfg_write(`CCGC_GENCTL_DW_ADDR, 4'hF, 32'h07FF_FFFF);
    cfg_read(`CCGC_GENCTL_DW_ADDR, 32'h041B_0000);
    check({power_switch_type_select_o, second_socket_disable_o,
           firewire_function_disable_o}, 3'h7);
    fw_req_i = 1'h1;
    repeat (2) @(negedge clock_i);
    check(fw_gnt_o, 1'h0);
    fw_req_i = 1'h0;
    do_reset(1'h1);
    cfg_read(`CCGC_GENCTL_DW_ADDR, 32'h040B_0000);
    cfg_read(`CCGC_SYSCTL_ADDR, 32'h0);
    check(id_write_enable_o, 1'h1);
    check({power_switch_type_select_o, firewire_function_disable_o}, 2'h3);
    do_reset(1'h0);
    cfg_write(8'h88, 4'hF, 32'hFFFF_FFFF);
    cfg_read(8'h88, 32'h0);
    cfg_read(`CCGC_SYSCTL_ADDR, 32'h0000_0020);
    for (int m = 0; m < 4; m++) begin
      cfg_write(`CCGC_GENCTL_DW_ADDR, 4'h4, {14'h0, 2'((m + 2) % 4), 16'h0});
      fw_req_i = 1'h1;
      card_req_i = 1'h1;
      @(negedge clock_i);
      g0 = {fw_gnt_o, card_gnt_o};
      @(negedge clock_i);
      check({g0, fw_gnt_o, card_gnt_o}, arb_exp[(m + 2) % 4]);
      fw_req_i = 1'h0;
      card_req_i = 1'h0;
    end
    @(negedge clock_i);
    card_req_i = 1'h1;
    repeat (2) @(negedge clock_i);
    check({fw_gnt_o, card_gnt_o}, 2'h1);
    close_out();
  end
endmodule
`default_nettype wire
